// *** common/fcde_pkg.sv ***
// package for the flag clear and decrement execution block:
// register map, command encodings, field positions and widths.
// assumes a 32-bit apb bus; offsets are byte addresses.
package fcde_pkg;

    // widths of core state
    localparam int DATA_W     = 4;
    localparam int MEM_ADDR_W = 7;
    localparam int MEM_DEPTH  = 128;
    localparam int PC_W       = 11;
    localparam int WDT_W      = 18;
    localparam int KICK_BITS  = 4;
    localparam int SER_W      = 2;
    localparam int IRQ_W      = 4;
    localparam int OFF_W      = 8;

    // register byte offsets
    localparam logic [OFF_W-1:0] REG_CMD      = 8'h00;
    localparam logic [OFF_W-1:0] REG_PC       = 8'h04;
    localparam logic [OFF_W-1:0] REG_CORE     = 8'h08;
    localparam logic [OFF_W-1:0] REG_PORT     = 8'h0c;
    localparam logic [OFF_W-1:0] REG_WDT      = 8'h10;
    localparam logic [OFF_W-1:0] REG_MADDR    = 8'h14;
    localparam logic [OFF_W-1:0] REG_MDATA    = 8'h18;
    localparam logic [OFF_W-1:0] REG_IRQ_STAT = 8'h1c;
    localparam logic [OFF_W-1:0] REG_IRQ_CLR  = 8'h20;
    localparam logic [OFF_W-1:0] REG_IRQ_EN   = 8'h24;

    // command word layout
    localparam int CMD_OP_LSB  = 0;
    localparam int CMD_OP_W    = 4;
    localparam int CMD_ARG_LSB = 8;
    localparam int CMD_ARG_W   = 8;

    // command opcodes
    localparam logic [CMD_OP_W-1:0] OP_CLR_PARAM  = 4'h1;
    localparam logic [CMD_OP_W-1:0] OP_CLR_PORT   = 4'h2;
    localparam logic [CMD_OP_W-1:0] OP_CLR_SERIAL = 4'h3;
    localparam logic [CMD_OP_W-1:0] OP_WDT_KICK   = 4'h4;
    localparam logic [CMD_OP_W-1:0] OP_DEC        = 4'h5;
    localparam logic [CMD_OP_W-1:0] OP_INTERRUPT_DISABLE_OP    = 4'h6;
    localparam logic [CMD_OP_W-1:0] OP_DSKNZ      = 4'h7;
    localparam logic [CMD_OP_W-1:0] OP_EN_INT     = 4'h8;

    // immediate bit that selects the slow watchdog clock
    localparam int PARAM_WDT_SEL_BIT = 3;

    // program counter steps
    localparam logic [PC_W-1:0] PC_STEP = 11'h001;
    localparam logic [PC_W-1:0] PC_SKIP = 11'h002;

    // watchdog prescaler divisors
    localparam int WDT_DIV_SLOW = 1024;
    localparam int WDT_DIV_FAST = 16;

    // core status register fields
    localparam int CORE_ACC_LSB = 0;
    localparam int CORE_CF_BIT  = 4;
    localparam int CORE_ZF_BIT  = 5;
    localparam int CORE_IE_BIT  = 6;
    localparam int CORE_WS_BIT  = 7;

    // port status register fields
    localparam int PORT_CHG_BIT = 0;
    localparam int PORT_SER_LSB = 4;

    // interrupt status bits
    localparam int IRQ_EXEC = 0;
    localparam int IRQ_SKIP = 1;
    localparam int IRQ_BAD  = 2;
    localparam int IRQ_WDT  = 3;

    // reset values
    localparam logic [PC_W-1:0]   RST_PC   = 11'h000;
    localparam logic [DATA_W-1:0] RST_DATA = 4'h0;
    localparam logic [WDT_W-1:0]  RST_WDT  = 18'h00000;

endpackage : fcde_pkg

// *** design/fcde_exec.sv ***
// execution logic for the flag clear, interrupt and decrement group,
// with its data memory, program counter and an apb register slave.
// assumes an apb master on clk; port_change_pin is asynchronous,
// serial done strobes are one-cycle pulses on clk.
//
// Behaviour
// - param flag clear op with I3 set selects sysclk/1024 watchdog clock
// - port status clear op resets the change detect port change flag
// - serial status clear op resets every serial port status flag
// - watchdog kick clears only the low four watchdog counter bits
// - memory decrement writes mem minus one to mem and accumulator, flags
// - interrupt disable op blocks interrupt acceptance until re-enabled
// - decrement skip op also advances program counter by two if nonzero
// - interrupt enable op restores interrupt acceptance
module fcde_exec
    import fcde_pkg::*;
#(
    parameter int DEPTH    = MEM_DEPTH,
    parameter int DIV_SLOW = WDT_DIV_SLOW,
    parameter int DIV_FAST = WDT_DIV_FAST
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // event sources
    input  wire logic              port_change_pin,
    input  wire logic              serial_rx_done,
    input  wire logic              serial_tx_done,
    // core state
    output logic      [DATA_W-1:0] accumulator,
    output logic                   carry_flag,
    output logic                   zero_flag,
    output logic      [PC_W-1:0]   pc,
    output logic                   interrupt_enable,
    output logic                   wdt_slow_sel,
    output logic                   port_change_status,
    output logic      [SER_W-1:0]  serial_port_status,
    output logic      [WDT_W-1:0]  wdt_count,
    // interrupt
    output logic                   irq
);

    // refuse a memory the address field cannot reach
    if (DEPTH < 2 || DEPTH > (1 << MEM_ADDR_W)) begin
        $error("fcde_exec: bad memory depth");
    end

    // byte offset of an apb address
    function automatic logic [OFF_W-1:0] reg_off(input logic [31:0] a);
        return a[OFF_W-1:0];
    endfunction : reg_off

    // true when an offset names a register
    function automatic logic is_mapped(input logic [OFF_W-1:0] o);
        return (o == REG_CMD) || (o == REG_PC) || (o == REG_CORE) ||
               (o == REG_PORT) || (o == REG_WDT) || (o == REG_MADDR) ||
               (o == REG_MDATA) || (o == REG_IRQ_STAT) ||
               (o == REG_IRQ_CLR) || (o == REG_IRQ_EN);
    endfunction : is_mapped

    // known opcode check
    function automatic logic is_known_op(input logic [CMD_OP_W-1:0] op);
        return (op == OP_CLR_PARAM) || (op == OP_CLR_PORT) ||
               (op == OP_CLR_SERIAL) || (op == OP_WDT_KICK) ||
               (op == OP_DEC) || (op == OP_INTERRUPT_DISABLE_OP) ||
               (op == OP_DSKNZ) || (op == OP_EN_INT);
    endfunction : is_known_op

    // state registers
    logic [DATA_W-1:0]     mem_ff [DEPTH];
    logic [DATA_W-1:0]     acc_ff;
    logic                  cf_ff;
    logic                  zf_ff;
    logic [PC_W-1:0]       pc_ff;
    logic                  ie_ff;
    logic                  wsel_ff;
    logic                  chg_ff;
    logic [SER_W-1:0]      ser_ff;
    logic [MEM_ADDR_W-1:0] maddr_ff;
    logic [31:0]           cmd_ff;
    logic [IRQ_W-1:0]      irq_stat_ff;
    logic [IRQ_W-1:0]      irq_en_ff;
    logic [31:0]           rdata_ff;
    logic                  err_ff;
    logic                  sync1_ff;
    logic                  sync2_ff;
    logic                  sync3_ff;
    logic                  lvl_ff;

    // decoded transfer and command
    logic                  wr_access;
    logic [OFF_W-1:0]      off;
    logic                  cmd_wr;
    logic [CMD_OP_W-1:0]   op;
    logic [CMD_ARG_W-1:0]  arg;
    logic [MEM_ADDR_W-1:0] op_addr;
    logic                  op_known;
    logic                  do_dec;
    logic                  do_skip;
    logic [DATA_W-1:0]     mem_rd;
    logic [DATA_W-1:0]     dec_val;
    logic                  dec_cf;
    logic                  wdt_kick;
    logic                  wdt_ovf;
    logic                  port_change;
    logic [IRQ_W-1:0]      irq_set;
    logic [IRQ_W-1:0]      irq_clr;
    logic [31:0]           rd_mux;
    logic [WDT_W-1:0]      wdt_cnt;

    // apb decode; the slave never inserts wait states
    assign off       = reg_off(paddr);
    assign wr_access = psel && penable && pwrite && is_mapped(off);
    assign pready    = 1'b1;
    assign prdata    = rdata_ff;
    assign pslverr   = err_ff && psel && penable;

    // a command write executes one instruction at that edge
    assign cmd_wr   = wr_access && (off == REG_CMD);
    assign op       = pwdata[CMD_OP_LSB +: CMD_OP_W];
    assign arg      = pwdata[CMD_ARG_LSB +: CMD_ARG_W];
    assign op_addr  = arg[MEM_ADDR_W-1:0];
    assign op_known = is_known_op(op);

    // decrement datapath shared by both decrement ops
    assign do_dec  = cmd_wr && ((op == OP_DEC) || (op == OP_DSKNZ));
    assign mem_rd  = mem_ff[op_addr];
    assign {dec_cf, dec_val} = {1'b0, mem_rd} + {1'b0, {DATA_W{1'b1}}};
    assign do_skip = cmd_wr && (op == OP_DSKNZ) &&
                     (dec_val != RST_DATA);
    assign wdt_kick = cmd_wr && (op == OP_WDT_KICK);

    // three-stage synchroniser for the change detect pin
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            sync3_ff <= 1'b0;
        end else begin
            sync1_ff <= port_change_pin;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // settled pin level; a change counts once stages two and three agree
    always_ff @(posedge clk) begin
        if (rst) begin
            lvl_ff <= 1'b0;
        end else if (sync2_ff == sync3_ff) begin
            lvl_ff <= sync3_ff;
        end
    end

    // a one-cycle glitch never reaches agreement and is dropped
    assign port_change = (sync2_ff == sync3_ff) && (sync3_ff != lvl_ff);

    // data memory: decrement writeback or software write
    always_ff @(posedge clk) begin
        if (do_dec) begin
            mem_ff[op_addr] <= dec_val;
        end else if (wr_access && (off == REG_MDATA)) begin
            mem_ff[maddr_ff] <= pwdata[DATA_W-1:0];
        end
    end

    // software memory pointer
    always_ff @(posedge clk) begin
        if (rst) begin
            maddr_ff <= '0;
        end else if (wr_access && (off == REG_MADDR)) begin
            maddr_ff <= pwdata[MEM_ADDR_W-1:0];
        end
    end

    // accumulator and flags from the decrement ops
    always_ff @(posedge clk) begin
        if (rst) begin
            acc_ff <= RST_DATA;
            cf_ff  <= 1'b0;
            zf_ff  <= 1'b0;
        end else if (do_dec) begin
            acc_ff <= dec_val;
            cf_ff  <= dec_cf;
            zf_ff  <= (dec_val == RST_DATA);
        end
    end

    // program counter: one step, two on a skip
    always_ff @(posedge clk) begin
        if (rst) begin
            pc_ff <= RST_PC;
        end else if (cmd_wr && op_known) begin
            pc_ff <= pc_ff + (do_skip ? PC_SKIP : PC_STEP);
        end else if (wr_access && (off == REG_PC)) begin
            pc_ff <= pwdata[PC_W-1:0];
        end
    end

    // interrupt enable switch
    always_ff @(posedge clk) begin
        if (rst) begin
            ie_ff <= 1'b0;
        end else if (cmd_wr && (op == OP_INTERRUPT_DISABLE_OP)) begin
            ie_ff <= 1'b0;
        end else if (cmd_wr && (op == OP_EN_INT)) begin
            ie_ff <= 1'b1;
        end
    end

    // watchdog clock select taken from immediate bit three
    always_ff @(posedge clk) begin
        if (rst) begin
            wsel_ff <= 1'b0;
        end else if (cmd_wr && (op == OP_CLR_PARAM)) begin
            wsel_ff <= arg[PARAM_WDT_SEL_BIT];
        end
    end

    // change flag; a new change wins over the clear
    always_ff @(posedge clk) begin
        if (rst) begin
            chg_ff <= 1'b0;
        end else if (port_change) begin
            chg_ff <= 1'b1;
        end else if (cmd_wr && (op == OP_CLR_PORT)) begin
            chg_ff <= 1'b0;
        end
    end

    // serial status flags; set wins over the clear
    always_ff @(posedge clk) begin
        if (rst) begin
            ser_ff <= '0;
        end else if (cmd_wr && (op == OP_CLR_SERIAL)) begin
            ser_ff <= {serial_tx_done, serial_rx_done};
        end else begin
            ser_ff <= ser_ff | {serial_tx_done, serial_rx_done};
        end
    end

    // watchdog counter and prescaler
    fcde_watchdog #(
        .CNT_W    (WDT_W),
        .DIV_SLOW (DIV_SLOW),
        .DIV_FAST (DIV_FAST)
    ) u_wdt (
        .clk      (clk),
        .rst      (rst),
        .slow_sel (wsel_ff),
        .kick     (wdt_kick),
        .count    (wdt_cnt),
        .overflow (wdt_ovf)
    );

    // last command word for readback
    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_ff <= '0;
        end else if (cmd_wr) begin
            cmd_ff <= pwdata;
        end
    end

    // interrupt events and software clears
    assign irq_set = {wdt_ovf,
                      cmd_wr && !op_known,
                      do_skip,
                      cmd_wr && op_known};
    assign irq_clr = (wr_access && (off == REG_IRQ_CLR)) ?
                     pwdata[IRQ_W-1:0] : '0;

    // sticky status; a set wins over a clear
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_stat_ff <= '0;
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
        end
    end

    // interrupt mask
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_en_ff <= '0;
        end else if (wr_access && (off == REG_IRQ_EN)) begin
            irq_en_ff <= pwdata[IRQ_W-1:0];
        end
    end

    // read mux for the register file
    always_comb begin
        rd_mux = '0;
        case (off)
            REG_CMD:      rd_mux = cmd_ff;
            REG_PC:       rd_mux[PC_W-1:0] = pc_ff;
            REG_CORE: begin
                rd_mux[CORE_ACC_LSB +: DATA_W] = acc_ff;
                rd_mux[CORE_CF_BIT] = cf_ff;
                rd_mux[CORE_ZF_BIT] = zf_ff;
                rd_mux[CORE_IE_BIT] = ie_ff;
                rd_mux[CORE_WS_BIT] = wsel_ff;
            end
            REG_PORT: begin
                rd_mux[PORT_CHG_BIT] = chg_ff;
                rd_mux[PORT_SER_LSB +: SER_W] = ser_ff;
            end
            REG_WDT:      rd_mux[WDT_W-1:0] = wdt_cnt;
            REG_MADDR:    rd_mux[MEM_ADDR_W-1:0] = maddr_ff;
            REG_MDATA:    rd_mux[DATA_W-1:0] = mem_ff[maddr_ff];
            REG_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_ff;
            REG_IRQ_EN:   rd_mux[IRQ_W-1:0] = irq_en_ff;
            default:      rd_mux = '0;
        endcase
    end

    // read data and error captured in the setup cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_ff <= '0;
            err_ff   <= 1'b0;
        end else if (psel && !penable) begin
            rdata_ff <= pwrite ? '0 : rd_mux;
            err_ff   <= !is_mapped(off);
        end
    end

    // interrupt only while accepted by the enable switch
    assign irq = ie_ff && (|(irq_stat_ff & irq_en_ff));

    // state outputs
    assign accumulator        = acc_ff;
    assign carry_flag         = cf_ff;
    assign zero_flag          = zf_ff;
    assign pc                 = pc_ff;
    assign interrupt_enable   = ie_ff;
    assign wdt_slow_sel       = wsel_ff;
    assign port_change_status = chg_ff;
    assign serial_port_status = ser_ff;
    assign wdt_count          = wdt_cnt;

endmodule : fcde_exec

// *** design/fcde_watchdog.sv ***
// watchdog counter with selectable prescaler and low-nibble kick.
// assumes kick is a one-cycle pulse from the same clock domain.
module fcde_watchdog
    import fcde_pkg::*;
#(
    parameter int CNT_W    = WDT_W,
    parameter int DIV_SLOW = WDT_DIV_SLOW,
    parameter int DIV_FAST = WDT_DIV_FAST
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // control
    input  wire logic             slow_sel,
    input  wire logic             kick,
    // state
    output logic      [CNT_W-1:0] count,
    output logic                  overflow
);

    localparam int PRE_W = $clog2(DIV_SLOW);
    localparam logic [PRE_W-1:0] PRE_SLOW_END = PRE_W'(DIV_SLOW - 1);
    localparam logic [PRE_W-1:0] PRE_FAST_END = PRE_W'(DIV_FAST - 1);

    // refuse shapes the logic cannot serve
    if (CNT_W <= KICK_BITS || DIV_FAST < 2 || DIV_FAST > DIV_SLOW) begin
        $error("fcde_watchdog: bad width or divisor");
    end

    logic [PRE_W-1:0] pre_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic             ovf_ff;
    logic             tick;
    logic [PRE_W-1:0] pre_end;

    // divisor chosen by the parameter flag
    assign pre_end = slow_sel ? PRE_SLOW_END : PRE_FAST_END;
    assign tick    = (pre_ff >= pre_end);

    // prescaler from the system clock
    always_ff @(posedge clk) begin
        if (rst || tick) begin
            pre_ff <= '0;
        end else begin
            pre_ff <= pre_ff + 1'b1;
        end
    end

    // counter; a kick clears only the low bits
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_ff <= '0;
        end else if (kick) begin
            cnt_ff <= {cnt_ff[CNT_W-1:KICK_BITS], KICK_BITS'(0)};
        end else if (tick) begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    // overflow pulse when the full count wraps
    always_ff @(posedge clk) begin
        if (rst) begin
            ovf_ff <= 1'b0;
        end else begin
            ovf_ff <= tick && !kick && (&cnt_ff);
        end
    end

    assign count    = cnt_ff;
    assign overflow = ovf_ff;

endmodule : fcde_watchdog

// *** tb/fcde_exec_chk.sv ***
// checker for the flag clear and decrement execution block.
// assumes it is bound to fcde_exec and sees only its ports.
module fcde_exec_chk
    import fcde_pkg::*;
#(
    parameter int DEPTH    = MEM_DEPTH,
    parameter int DIV_SLOW = WDT_DIV_SLOW,
    parameter int DIV_FAST = WDT_DIV_FAST
) (
    // clock and reset
    input wire logic              clk,
    input wire logic              rst,
    // apb request side
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [31:0]       paddr,
    input wire logic [31:0]       pwdata,
    // event sources
    input wire logic              port_change_pin,
    input wire logic              serial_rx_done,
    input wire logic              serial_tx_done,
    // core state
    input wire logic [DATA_W-1:0] accumulator,
    input wire logic              carry_flag,
    input wire logic              zero_flag,
    input wire logic [PC_W-1:0]   pc,
    input wire logic              interrupt_enable,
    input wire logic              wdt_slow_sel,
    input wire logic              port_change_status,
    input wire logic [SER_W-1:0]  serial_port_status,
    input wire logic [WDT_W-1:0]  wdt_count,
    input wire logic              irq
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // recent pin samples; quiet when no change is in flight
    logic [4:0] pin_hist_ff;
    logic       pin_quiet;
    always_ff @(posedge clk) begin
        pin_hist_ff <= {pin_hist_ff[3:0], port_change_pin};
    end
    assign pin_quiet = (pin_hist_ff == 5'h00) || (pin_hist_ff == 5'h1f);

    // command register write of one opcode
    sequence s_cmd(logic [CMD_OP_W-1:0] op);
        psel && penable && pwrite && paddr[7:0] == REG_CMD
            && pwdata[CMD_OP_W-1:0] == op;
    endsequence

    wdt_sel_a: assert property (s_cmd(OP_CLR_PARAM) |=>
        wdt_slow_sel == $past(pwdata[CMD_ARG_LSB+PARAM_WDT_SEL_BIT]))
        else $error("clock select not taken from immediate");
    port_clr_a: assert property (s_cmd(OP_CLR_PORT) ##0 pin_quiet
        |=> !port_change_status)
        else $error("change flag not cleared");
    ser_clr_a: assert property (s_cmd(OP_CLR_SERIAL)
        ##0 !(serial_rx_done || serial_tx_done) |=> serial_port_status == '0)
        else $error("serial flags not cleared");
    kick_low_a: assert property (s_cmd(OP_WDT_KICK) |=>
        wdt_count[KICK_BITS-1:0] == '0
        && $stable(wdt_count[WDT_W-1:KICK_BITS]))
        else $error("kick touched wrong counter bits");
    dec_flags_a: assert property (
        (s_cmd(OP_DEC) or s_cmd(OP_DSKNZ))
        |=> zero_flag == (accumulator == 4'h0)
        && carry_flag == (accumulator != 4'hf))
        else $error("decrement flags wrong");
    pc_step_a: assert property (
        (s_cmd(OP_DEC) or s_cmd(OP_WDT_KICK))
        |=> pc == $past(pc) + PC_STEP)
        else $error("pc did not step by one");
    skip_step_a: assert property (s_cmd(OP_DSKNZ) |=>
        pc == $past(pc) + ((accumulator != 4'h0) ? PC_SKIP : PC_STEP))
        else $error("skip step wrong");
    interrupt_disable_op_a: assert property (s_cmd(OP_INTERRUPT_DISABLE_OP)
        |=> !interrupt_enable && !irq)
        else $error("interrupts still on after disable");
    irq_gate_a: assert property (!interrupt_enable |-> !irq)
        else $error("irq while interrupts disabled");
    en_int_a: assert property (
        s_cmd(OP_EN_INT) |=> interrupt_enable)
        else $error("interrupts not enabled");
endmodule : fcde_exec_chk

bind fcde_exec fcde_exec_chk #(.DEPTH(DEPTH), .DIV_SLOW(DIV_SLOW),
    .DIV_FAST(DIV_FAST)) i_chk (.clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .port_change_pin, .serial_rx_done, .serial_tx_done,
    .accumulator, .carry_flag, .zero_flag, .pc, .interrupt_enable,
    .wdt_slow_sel, .port_change_status, .serial_port_status, .wdt_count,
    .irq);

// *** tb/fcde_exec_tb_top.sv ***
// self-checking bench for the flag clear and decrement block.
// assumes fcde_exec with shortened watchdog divisors, apb at 25 MHz.
module fcde_exec_tb_top
    import fcde_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct {
        logic [3:0]      op;
        logic [6:0]      a;
        logic [3:0]      m, r;
        logic            c, z;
        logic [PC_W-1:0] st;
    } fcde_row_s;

    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0]       paddr = '0, pwdata = '0, prdata, rd;
    logic              pready, pslverr, err;
    logic              port_change_pin = 1'b0;
    logic              serial_rx_done = 1'b0, serial_tx_done = 1'b0;
    logic [DATA_W-1:0] accumulator;
    logic              carry_flag, zero_flag, interrupt_enable, irq;
    logic              wdt_slow_sel, port_change_status;
    logic [PC_W-1:0]   pc, p0;
    logic [SER_W-1:0]  serial_port_status;
    logic [WDT_W-1:0]  wdt_count, w0;
    int                fails = 0, check_count = 0;
    // decrement cases: op, address, memory, result, cf, zf, pc step
    fcde_row_s rows [6] = '{
        '{OP_DEC,   7'h05, 4'h5, 4'h4, 1'b1, 1'b0, PC_STEP},
        '{OP_DEC,   7'h7f, 4'h1, 4'h0, 1'b1, 1'b1, PC_STEP},
        '{OP_DEC,   7'h00, 4'h0, 4'hf, 1'b0, 1'b0, PC_STEP},
        '{OP_DSKNZ, 7'h10, 4'h3, 4'h2, 1'b1, 1'b0, PC_SKIP},
        '{OP_DSKNZ, 7'h7e, 4'h1, 4'h0, 1'b1, 1'b1, PC_STEP},
        '{OP_DSKNZ, 7'h01, 4'h0, 4'hf, 1'b0, 1'b0, PC_SKIP}};

    fcde_exec #(.DEPTH(MEM_DEPTH), .DIV_SLOW(32), .DIV_FAST(4)) i_dut (
        .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .port_change_pin, .serial_rx_done,
        .serial_tx_done, .accumulator, .carry_flag, .zero_flag, .pc,
        .interrupt_enable, .wdt_slow_sel, .port_change_status,
        .serial_port_status, .wdt_count, .irq);

    // 25 MHz clock
    always #20 clk = ~clk;

    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %0t %s: %h vs %h", $time, what, seen, exp);
        end
    endtask : check

    // one apb transfer; answer taken at the edge where pready is high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {24'h0, a};
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        // wait for the edge with pready high; the loop has no timeout of its own
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // execute one op, return where its results have settled
    task automatic cmd(input logic [3:0] op, input logic [7:0] arg);
        apb(1'b1, REG_CMD, {16'h0, arg, 4'h0, op});
        @(negedge clk);
    endtask : cmd

    task automatic done(input string t);
        $display("test %s done", t);
    endtask : done

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check({accumulator, carry_flag, zero_flag, interrupt_enable,
               wdt_slow_sel, port_change_status, serial_port_status, irq,
               pc}, '0, "reset state");
        done("reset");
        foreach (rows[i]) begin
            apb(1'b1, REG_MADDR, {25'h0, rows[i].a});
            apb(1'b1, REG_MDATA, {28'h0, rows[i].m});
            p0 = pc;
            cmd(rows[i].op, {1'b0, rows[i].a});
            check(accumulator, rows[i].r, "acc");
            check({carry_flag, zero_flag},
                  {rows[i].c, rows[i].z}, "cf zf");
            check(pc, p0 + rows[i].st, "pc step");
            apb(1'b0, REG_MDATA, '0);
            check(rd, {28'h0, rows[i].r}, "memory");
        end
        done("decrement table");
        // unknown op and unmapped offset
        p0 = pc;
        cmd(4'hf, 8'h00);
        check(pc, p0, "unknown op pc");
        apb(1'b0, REG_IRQ_STAT, '0);
        check(rd[IRQ_BAD], 1'b1, "bad op status");
        apb(1'b0, 8'h40, '0);
        check(err, 1'b1, "unmapped error");
        check(rd, '0, "unmapped data");
        done("refusals");
        // interrupt enable, disable, mask and clear
        apb(1'b1, REG_IRQ_CLR, 32'hf);
        apb(1'b1, REG_IRQ_EN, 32'h1);
        cmd(OP_INTERRUPT_DISABLE_OP, 8'h00);
        check({interrupt_enable, irq}, 2'b00, "disabled");
        cmd(OP_EN_INT, 8'h00);
        check({interrupt_enable, irq}, 2'b11, "enabled");
        cmd(OP_INTERRUPT_DISABLE_OP, 8'h00);
        check({interrupt_enable, irq}, 2'b00, "disabled again");
        cmd(OP_EN_INT, 8'h00);
        apb(1'b1, REG_IRQ_EN, '0);
        @(negedge clk);
        check(irq, 1'b0, "masked");
        apb(1'b1, REG_IRQ_EN, 32'h1);
        apb(1'b1, REG_IRQ_CLR, 32'h1);
        @(negedge clk);
        check(irq, 1'b0, "cleared");
        done("interrupts");
        // clock select, slow rate and kick
        cmd(OP_CLR_PARAM, 8'h07);
        check(wdt_slow_sel, 1'b0, "reserved bits");
        cmd(OP_CLR_PARAM, 8'h08);
        check(wdt_slow_sel, 1'b1, "slow select");
        w0 = wdt_count;
        repeat (320) @(negedge clk);
        w0 = wdt_count - w0;
        check(32'(w0 >= 9 && w0 <= 11), 32'h1, "slow rate");
        // take the count just before the kick edge; a tick at that edge is lost to the kick
        fork
            cmd(OP_WDT_KICK, 8'h00);
            begin
                repeat (2) @(posedge clk);
                @(negedge clk);
                w0 = wdt_count;
            end
        join
        check(wdt_count[3:0], '0, "kick low");
        check(wdt_count[WDT_W-1:4], w0[WDT_W-1:4], "kick high");
        done("watchdog");
        // port change and serial flags
        @(posedge clk);
        port_change_pin <= 1'b1;
        serial_rx_done  <= 1'b1;
        serial_tx_done  <= 1'b1;
        @(posedge clk);
        serial_rx_done  <= 1'b0;
        serial_tx_done  <= 1'b0;
        repeat (6) @(negedge clk);
        check({port_change_status, serial_port_status}, 3'h7, "events");
        cmd(OP_CLR_PORT, 8'h00);
        check({port_change_status, serial_port_status},
              3'h3, "port clr");
        cmd(OP_CLR_SERIAL, 8'h00);
        check(serial_port_status, '0, "serial clr");
        done("status flags");
        summarize();
    end

    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        summarize();
    end
endmodule : fcde_exec_tb_top
